/* File: core/pzp_consts.svh */
/*
  Constants of the port zero pin control block: register offsets,
  fixed bit values, reset values and field positions.
  Assumes inclusion by bare name from design files under core/.
*/
`ifndef PZP_CONSTS_SVH
`define PZP_CONSTS_SVH

// ==========================================================
// Register byte addresses on the Avalon-MM slave
`define PZP_ADDR_W          4
`define PZP_OFS_ANALOG      4'h0
`define PZP_OFS_LATCH       4'h4
`define PZP_OFS_DIR         4'h8
`define PZP_OFS_PULLUP      4'hc

// ==========================================================
// Pin count and field layout
`define PZP_NPINS           5
`define PZP_TOP_BITS        3
`define PZP_ANALOG_FIX_LO   1'h1
`define PZP_ONES_TOP        3'h7
`define PZP_ZEROS_TOP       3'h0
`define PZP_UNMAPPED_DATA   32'h0000_0000

// ==========================================================
// Reset values of the programmable fields
`define PZP_RST_ANALOG      4'h0
`define PZP_RST_LATCH       5'h00
`define PZP_RST_DIR         5'h1f
`define PZP_RST_PULLUP      5'h00

`endif

/* File: core/pzp_pkg.sv */
/*
  Types of the port zero pin control block.
  Assumes pzp_consts.svh sits in the same folder.
*/
`include "pzp_consts.svh"

package pzp_pkg;

  // ========================================================
  // Bus answer state
  typedef enum logic [0:0] {
    PZP_IDLE = 1'b0,
    PZP_ACK  = 1'b1
  } pzp_bus_state_type;

  typedef logic [`PZP_NPINS-1:0] pzp_pins_type;

endpackage

/* File: core/pzp_sync.sv */
/*
  Two-flip-flop synchroniser for one pin input.
  Assumes mclk domain, rstn asynchronous active low.
*/
`timescale 1ns/10ps

module pzp_sync (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic clk_en,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_r;

  // ========================================================
  // Two-stage sampling; first stage feeds only the second
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_r   <= 1'b0;
      sync_out <= 1'b0;
    end else if (clk_en) begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

/* File: core/pzp_pin_cell.sv */
/*
  One pin of port zero: output enable, driven level, pull-up and
  analog routing from the register bits of that pin.
  Assumes register bits come from the mclk domain.
*/
`timescale 1ns/10ps

module pzp_pin_cell #(
  parameter bit HAS_ANALOG = 1'b1
) (
  input  wire logic latch_bit,
  input  wire logic dir_bit,
  input  wire logic pullup_bit,
  input  wire logic analog_bit,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      pin_pullup,
  output logic      pin_analog
);

  logic analog_sel;

  // ========================================================
  // Pin 0 has no analog path
  assign analog_sel = HAS_ANALOG & analog_bit;              // RULE_01

  // ========================================================
  // Output buffer on when direction bit is 0 and pin is digital
  assign pin_oe     = ~dir_bit & ~analog_sel;               // RULE_05
  assign pin_out    = latch_bit;                            // RULE_04
  assign pin_pullup = pullup_bit & ~analog_sel;             // RULE_07
  assign pin_analog = analog_sel;                           // RULE_01

endmodule

/* File: core/pzp_port.sv */
/*
  Port zero pin control: four registers over Avalon-MM with
  waitrequest, driving five general-purpose pins.
  Assumes one clock mclk at 20 MHz, asynchronous active-low rstn,
  pins driven outside through the output enables given here.
*/
`timescale 1ns/10ps
`include "pzp_consts.svh"

// Notes on behaviour
// [RULE_01] Pins 1-4: analog bit 0 selects digital path, 1 selects analog input.
// [RULE_02] Analog-select bits 7..5 and bit 0 always read 1.
// [RULE_03] Output latch holds pins 0-4 in bits 4..0; bits 7..5 read 0.
// [RULE_04] In output mode latch bit 0 drives low, 1 drives high.
// [RULE_05] Direction bit 0 enables output buffer, 1 leaves pin input.
// [RULE_06] Direction bits 7..5 always read 1.
// [RULE_07] Pull-up bit 1 connects pull-up, 0 leaves it off; bits 7..5 read 0.
// [RULE_08] Latch read returns synchronised pin level for input-mode pins.
module pzp_port (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [4:0]  pin_in,
  output logic [4:0]       pin_out,
  output logic [4:0]       pin_oe,
  output logic [4:0]       pin_pullup,
  output logic [4:0]       pin_analog
);

  // ========================================================
  // Register state
  logic [3:0]                analog_r;
  pzp_pkg::pzp_pins_type     latch_r;
  pzp_pkg::pzp_pins_type     dir_r;
  pzp_pkg::pzp_pins_type     pullup_r;
  pzp_pkg::pzp_pins_type     pin_sync;
  pzp_pkg::pzp_bus_state_type state_r;
  pzp_pkg::pzp_bus_state_type state_nxt;
  logic [31:0]               rdata_nxt;

  // ========================================================
  // Address decode
  wire sel_analog = (avs_address == `PZP_OFS_ANALOG);
  wire sel_latch  = (avs_address == `PZP_OFS_LATCH);
  wire sel_dir    = (avs_address == `PZP_OFS_DIR);
  wire sel_pullup = (avs_address == `PZP_OFS_PULLUP);
  wire req        = clk_en & (avs_read | avs_write);
  wire take       = req & (state_r == pzp_pkg::PZP_IDLE);
  wire wr_lane0   = take & avs_write & avs_byteenable[0];

  // ========================================================
  // Readback views with fixed bits
  wire [7:0] analog_view = {`PZP_ONES_TOP, analog_r, `PZP_ANALOG_FIX_LO}; // RULE_02
  wire [4:0] latch_mix   = (latch_r & ~dir_r) | (pin_sync & dir_r);       // RULE_08
  wire [7:0] latch_view  = {`PZP_ZEROS_TOP, latch_mix};                   // RULE_03
  wire [7:0] dir_view    = {`PZP_ONES_TOP, dir_r};                        // RULE_06
  wire [7:0] pullup_view = {`PZP_ZEROS_TOP, pullup_r};                    // RULE_07

  // Read data select; unmapped reads zero
  assign rdata_nxt = sel_analog ? {24'h000000, analog_view} :
                     sel_latch  ? {24'h000000, latch_view}  :
                     sel_dir    ? {24'h000000, dir_view}    :
                     sel_pullup ? {24'h000000, pullup_view} :
                     `PZP_UNMAPPED_DATA;

  // ========================================================
  // One wait cycle, then answer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      pzp_pkg::PZP_IDLE: begin
        if (req) begin
          state_nxt = pzp_pkg::PZP_ACK;
        end
      end
      pzp_pkg::PZP_ACK: begin
        if (clk_en) begin
          state_nxt = pzp_pkg::PZP_IDLE;
        end
      end
    endcase
  end

  assign avs_waitrequest = ~(state_r == pzp_pkg::PZP_ACK) | ~clk_en;

  // Bus state and read data
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r      <= pzp_pkg::PZP_IDLE;
      avs_readdata <= `PZP_UNMAPPED_DATA;
    end else if (clk_en) begin
      state_r <= state_nxt;
      if (take & avs_read) begin
        avs_readdata <= rdata_nxt;
      end
    end
  end

  // ========================================================
  // Register writes, low byte lane only
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      analog_r <= `PZP_RST_ANALOG;
      latch_r  <= `PZP_RST_LATCH;
      dir_r    <= `PZP_RST_DIR;
      pullup_r <= `PZP_RST_PULLUP;
    end else if (wr_lane0) begin
      if (sel_analog) begin
        analog_r <= avs_writedata[4:1];                     // RULE_02
      end
      if (sel_latch) begin
        latch_r <= avs_writedata[4:0];                      // RULE_03
      end
      if (sel_dir) begin
        dir_r <= avs_writedata[4:0];                        // RULE_06
      end
      if (sel_pullup) begin
        pullup_r <= avs_writedata[4:0];                     // RULE_07
      end
    end
  end

  // ========================================================
  // Pin input synchronisers
  genvar gi;
  generate
    for (gi = 0; gi < `PZP_NPINS; gi++) begin : g_sync
      pzp_sync u_sync (
        .mclk     (mclk),
        .rstn     (rstn),
        .clk_en   (clk_en),
        .async_in (pin_in[gi]),
        .sync_out (pin_sync[gi])
      );
    end
  endgenerate

  // ========================================================
  // Pin cells; pin 0 has no analog bit
  pzp_pin_cell #(.HAS_ANALOG(1'b0)) u_cell0 (
    .latch_bit  (latch_r[0]),
    .dir_bit    (dir_r[0]),
    .pullup_bit (pullup_r[0]),
    .analog_bit (1'b0),
    .pin_out    (pin_out[0]),
    .pin_oe     (pin_oe[0]),
    .pin_pullup (pin_pullup[0]),
    .pin_analog (pin_analog[0])
  );

  generate
    for (gi = 1; gi < `PZP_NPINS; gi++) begin : g_cell
      pzp_pin_cell #(.HAS_ANALOG(1'b1)) u_cell (
        .latch_bit  (latch_r[gi]),
        .dir_bit    (dir_r[gi]),
        .pullup_bit (pullup_r[gi]),
        .analog_bit (analog_r[gi-1]),                       // RULE_01
        .pin_out    (pin_out[gi]),
        .pin_oe     (pin_oe[gi]),
        .pin_pullup (pin_pullup[gi]),
        .pin_analog (pin_analog[gi])
      );
    end
  endgenerate

endmodule

/* File: bench/pzp_board.sv */
/* Board circuitry on the five port pins.
   Assumes pin controls from pzp_port and a bench-driven source. */
`timescale 1ns/10ps
module pzp_board (
  input  wire logic       mclk,
  input  wire logic [4:0] pin_out,
  input  wire logic [4:0] pin_oe,
  input  wire logic [4:0] pin_pullup,
  input  wire logic [4:0] ext_lvl,
  input  wire logic       ext_en,
  output logic [4:0]      pin_in
);
  // ==========================================================
  // Floating lines change every cycle
  logic [4:0] float_r;
  initial float_r = 5'h0a;
  always @(posedge mclk) begin
    float_r <= ~float_r;
  end
  // Own buffer wins, then board source, then pull-up
  assign pin_in = (pin_oe & pin_out) |
                  (~pin_oe & (ext_en ? ext_lvl : (pin_pullup | float_r)));
endmodule

/* File: bench/pzp_monitor.sv */
/* Port checks of pzp_port.
   Assumes bind onto pzp_port, offsets 0, 4, 8 and c. */
`timescale 1ns/10ps
module pzp_monitor (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [4:0]  pin_out,
  input wire logic [4:0]  pin_oe,
  input wire logic [4:0]  pin_pullup,
  input wire logic [4:0]  pin_analog
);
  // ==========================================================
  // Completed accesses
  wire       wr_ok = avs_write & ~avs_waitrequest & avs_byteenable[0];
  wire       rd_ok = avs_read & ~avs_waitrequest;
  wire [7:0] rq    = avs_readdata[7:0];
  wire [4:0] wd    = avs_writedata[4:0];
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // Assertions
  an_zero_a: assert property (pin_analog[0] == 1'b0)
    else $error("pin zero analog");
  an_wr_a: assert property (wr_ok && avs_address == 4'h0 |-> pin_analog == {wd[4:1], 1'b0})
    else $error("analog select");
  an_rd_a: assert property (rd_ok && avs_address == 4'h0 |-> rq[7:5] == 3'h7 && rq[0])
    else $error("analog fixed bits");
  lt_rd_a: assert property (rd_ok && avs_address == 4'h4 |-> rq[7:5] == 3'h0)
    else $error("latch fixed bits");
  lt_wr_a: assert property (wr_ok && avs_address == 4'h4 |-> pin_out == wd)
    else $error("driven level");
  oe_wr_a: assert property (wr_ok && avs_address == 4'h8 |-> pin_oe == (~wd & ~pin_analog))
    else $error("output enable");
  dir_rd_a: assert property (rd_ok && avs_address == 4'h8 |-> rq[7:5] == 3'h7)
    else $error("direction fixed bits");
  pu_wr_a: assert property (wr_ok && avs_address == 4'hc |-> pin_pullup == (wd & ~pin_analog))
    else $error("pull-up enable");
endmodule
bind pzp_port pzp_monitor pzp_monitor_i (.mclk, .rstn, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .pin_out, .pin_oe,
  .pin_pullup, .pin_analog);

/* File: bench/tb_port_zero_pin_control.sv */
/* Self-checking bench of pzp_port with board model.
   Assumes pzp_port, pzp_board and the bound monitor. */
`timescale 1ns/10ps
module tb_port_zero_pin_control;
  logic        mclk, rstn, avs_read, avs_write, avs_waitrequest, ext_en;
  logic [3:0]  avs_address, be;
  logic        ce;
  logic [31:0] avs_writedata, avs_readdata, rdv;
  logic [4:0]  pin_in, pin_out, pin_oe, pin_pullup, pin_analog, ext_lvl;
  int          mismatches, samples_checked;
  // Rows of address, write data, readback
  logic [19:0] rows [8] = '{20'h800e0, 20'h4ff1f, 20'h40a0a, 20'hcff1f,
                            20'hc0505, 20'h01eff, 20'h000e1, 20'h1ff00};
  pzp_port pzp_port_i (.mclk, .rstn, .clk_en(ce), .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(be), .avs_readdata, .avs_waitrequest, .pin_in,
    .pin_out, .pin_oe, .pin_pullup, .pin_analog);
  pzp_board pzp_board_i (.mclk, .pin_out, .pin_oe, .pin_pullup, .ext_lvl, .ext_en, .pin_in);
  // ==========================================================
  // Clock, checks, bus access
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h0, d};
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    rdv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic conclude;
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Sequence
  initial begin
    {rstn, avs_read, avs_write, ext_en, avs_address, avs_writedata, ext_lvl} = '0;
    be = 4'hf;
    ce = 1'b1;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, rows[i][19:16], rows[i][15:8]);
      bus(1'b0, rows[i][19:16], 8'h00);
      chk("readback", {24'h0, rows[i][7:0]}, rdv);
    end
    chk("pins", {5'h0a, 5'h1f, 5'h05}, {pin_out, pin_oe, pin_pullup});
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("reset pins", {pin_oe, pin_pullup, pin_analog}, 32'h0);
    rstn <= 1'b1;
    bus(1'b0, 4'h8, 8'h00);
    chk("direction", 32'hff, rdv);
    ext_lvl <= 5'h15;
    ext_en <= 1'b1;
    repeat (3) @(posedge mclk);
    bus(1'b0, 4'h4, 8'h00);
    chk("input level", 32'h15, rdv);
    ext_en <= 1'b0;
    bus(1'b1, 4'hc, 8'hff);
    repeat (3) @(posedge mclk);
    bus(1'b0, 4'h4, 8'h00);
    chk("pulled level", 32'h1f, rdv);
    // Write with lane 0 off is ignored
    be <= 4'he;
    bus(1'b1, 4'hc, 8'h00);
    be <= 4'hf;
    bus(1'b0, 4'hc, 8'h00);
    chk("lane off write", 32'h1f, rdv);
    // Clock enable low holds waitrequest high
    ce <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("frozen wait", 32'h1, {31'h0, avs_waitrequest});
    ce <= 1'b1;
    bus(1'b0, 4'h8, 8'h00);
    chk("after freeze", 32'hff, rdv);
    conclude();
  end
  // Watchdog
  initial begin
    repeat (2000) @(posedge mclk);
    mismatches++;
    conclude();
  end
endmodule
